// ==== hw/ubs_break_unit.sv ====
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/10ps
module ubs_break_unit #(
	parameter int DEPTH = ubs_pkg::TRACE_DEPTH,
	parameter int CNT_W = ubs_pkg::EXEC_W
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata,
	input wire logic bus_valid,
	input wire logic bus_dma,
	input wire logic bus_fetch,
	input wire logic bus_write,
	input wire logic [1:0] bus_size,
	input wire logic [31:0] bus_addr,
	input wire logic [31:0] bus_data,
	input wire logic xy_valid,
	input wire logic xy_is_y,
	input wire logic xy_write,
	input wire logic [15:0] xy_addr,
	input wire logic [15:0] xy_data,
	input wire logic br_take,
	input wire logic br_short_repeat,
	input wire logic [31:0] br_dest,
	input wire logic [31:0] br_last_fetch,
	input wire logic [ubs_pkg::TF_PTR_W-1:0] br_pointer,
	input wire logic br_delay_intr,
	input wire logic [31:0] br_pending_dest,
	output logic break_req,
	output logic break_after_exec,
	output logic [3:0] break_level
);
	import ubs_pkg::*;

	localparam int PW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
		$error("trace depth must be a power of two");
	end
	if (CNT_W < 2 || CNT_W > 32) begin : g_bad_count
		$error("count width out of range");
	end

	// configuration registers
	logic [31:0] c1_addr_q, c1_addr_d, c1_amask_q, c1_amask_d;
	logic [31:0] c2_addr_q, c2_addr_d, c2_amask_q, c2_amask_d;
	logic [31:0] c2_data_q, c2_data_d, c2_dmask_q, c2_dmask_d;
	logic [BUS_W-1:0] c1_bus_q, c1_bus_d, c2_bus_q, c2_bus_d;
	logic pp1_q, pp1_d, pp2_q, pp2_d, seq_q, seq_d;
	logic exec_en_q, exec_en_d, trace_en_q, trace_en_d;

	logic wr_ctrl;
	assign wr_ctrl = reg_we && (reg_addr == OFS_CTRL);

	always_comb begin
		c1_addr_d = c1_addr_q;
		c1_amask_d = c1_amask_q;
		c1_bus_d = c1_bus_q;
		c2_addr_d = c2_addr_q;
		c2_amask_d = c2_amask_q;
		c2_data_d = c2_data_q;
		c2_dmask_d = c2_dmask_q;
		c2_bus_d = c2_bus_q;
		pp1_d = pp1_q;
		pp2_d = pp2_q;
		seq_d = seq_q;
		exec_en_d = exec_en_q;
		trace_en_d = trace_en_q;
		if (reg_we) begin
			if (reg_addr == OFS_C1_ADDR) begin
				c1_addr_d = reg_wdata;
			end else if (reg_addr == OFS_C1_AMASK) begin
				c1_amask_d = reg_wdata;
			end else if (reg_addr == OFS_C1_BUS) begin
				// channel one has no X/Y fields
				c1_bus_d = {2'b00, reg_wdata[BC_XYE-1:0]};
			end else if (reg_addr == OFS_C2_ADDR) begin
				c2_addr_d = reg_wdata;
			end else if (reg_addr == OFS_C2_AMASK) begin
				c2_amask_d = reg_wdata;
			end else if (reg_addr == OFS_C2_DATA) begin
				c2_data_d = reg_wdata;
			end else if (reg_addr == OFS_C2_DMASK) begin
				c2_dmask_d = reg_wdata;
			end else if (reg_addr == OFS_C2_BUS) begin
				c2_bus_d = reg_wdata[BUS_W-1:0];
			end else if (reg_addr == OFS_CTRL) begin
				pp1_d = reg_wdata[CT_PP1];
				pp2_d = reg_wdata[CT_PP2];
				seq_d = reg_wdata[CT_SEQ];
				exec_en_d = reg_wdata[CT_EXEC];
				trace_en_d = reg_wdata[CT_TRACE];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			c1_addr_q <= 32'h0;
			c1_amask_q <= 32'h0;
			c1_bus_q <= BUS_RST;
			c2_addr_q <= 32'h0;
			c2_amask_q <= 32'h0;
			c2_data_q <= 32'h0;
			c2_dmask_q <= 32'h0;
			c2_bus_q <= BUS_RST;
			pp1_q <= 1'b0;
			pp2_q <= 1'b0;
			seq_q <= 1'b0;
			exec_en_q <= 1'b0;
			trace_en_q <= 1'b0;
		end else if (ce) begin
			c1_addr_q <= c1_addr_d;
			c1_amask_q <= c1_amask_d;
			c1_bus_q <= c1_bus_d;
			c2_addr_q <= c2_addr_d;
			c2_amask_q <= c2_amask_d;
			c2_data_q <= c2_data_d;
			c2_dmask_q <= c2_dmask_d;
			c2_bus_q <= c2_bus_d;
			pp1_q <= pp1_d;
			pp2_q <= pp2_d;
			seq_q <= seq_d;
			exec_en_q <= exec_en_d;
			trace_en_q <= trace_en_d;
		end
	end

	// channel two input steering
	logic xy_bus_enable, xy_bus_select;
	logic c2_valid, c2_dma, c2_fetch, c2_write;
	logic [1:0] c2_size;
	logic [31:0] c2_baddr, c2_bdata, c2_bar, c2_bamr, c2_bdr, c2_bdmr;

	always_comb begin
		xy_bus_enable = c2_bus_q[BC_XYE];
		xy_bus_select = c2_bus_q[BC_XYS];
		if (xy_bus_enable) begin
			// X/Y cycles are CPU data words; main bus ignored
			c2_valid = xy_valid && (xy_is_y == xy_bus_select);
			c2_dma = 1'b0;
			c2_fetch = 1'b0;
			c2_write = xy_write;
			c2_size = BSZ_WORD;
			c2_baddr = {16'h0, xy_addr};
			c2_bdata = {16'h0, xy_data};
			c2_bar = {16'h0, xy_bus_select ? c2_addr_q[15:0] : c2_addr_q[31:16]};
			c2_bamr = {16'h0, xy_bus_select ? c2_amask_q[15:0] : c2_amask_q[31:16]};
			c2_bdr = {16'h0, xy_bus_select ? c2_data_q[15:0] : c2_data_q[31:16]};
			c2_bdmr = {16'h0, xy_bus_select ? c2_dmask_q[15:0] : c2_dmask_q[31:16]};
		end else begin
			c2_valid = bus_valid;
			c2_dma = bus_dma;
			c2_fetch = bus_fetch;
			c2_write = bus_write;
			c2_size = bus_size;
			c2_baddr = bus_addr;
			c2_bdata = bus_data;
			c2_bar = c2_addr_q;
			c2_bamr = c2_amask_q;
			c2_bdr = c2_data_q;
			c2_bdmr = c2_dmask_q;
		end
	end

	logic c1_match, c2_match;

	ubs_chan_cmp #(.HAS_DATA(1'b0)) u_cmp1 (
		.cyc(c1_bus_q),
		.bar(c1_addr_q),
		.bamr(c1_amask_q),
		.bdr(32'h0),
		.bdmr(32'h0),
		.valid(bus_valid),
		.dma(bus_dma),
		.fetch(bus_fetch),
		.write(bus_write),
		.size(bus_size),
		.addr(bus_addr),
		.data(bus_data),
		.match(c1_match)
	);

	ubs_chan_cmp #(.HAS_DATA(1'b1)) u_cmp2 (
		.cyc(c2_bus_q),
		.bar(c2_bar),
		.bamr(c2_bamr),
		.bdr(c2_bdr),
		.bdmr(c2_bdmr),
		.valid(c2_valid),
		.dma(c2_dma),
		.fetch(c2_fetch),
		.write(c2_write),
		.size(c2_size),
		.addr(c2_baddr),
		.data(c2_bdata),
		.match(c2_match)
	);

	// break sequencing, count and sticky flags
	logic [3:0] flags_q, flags_d;
	logic armed_q, armed_d;
	logic [CNT_W-1:0] exec_q, exec_d;
	logic brk_q, brk_d, after_q, after_d;
	logic c1_prefetch, armed_now, c2_fire, brk1, brk2;
	logic [3:0] fset, fclr;

	always_comb begin
		c1_prefetch = c1_bus_q[BC_FETCH] && !c1_bus_q[BC_DATA] && !pp1_q;
		armed_now = armed_q || (c1_match && c1_prefetch);
		c2_fire = c2_match && (!exec_en_q || exec_q == CNT_W'(EXEC_LAST));
		exec_d = exec_q;
		if (c2_match && exec_en_q && exec_q > CNT_W'(EXEC_LAST))
			exec_d = exec_q - CNT_W'(1);
		if (reg_we && reg_addr == OFS_EXEC)
			exec_d = reg_wdata[CNT_W-1:0];
		if (seq_q) begin
			brk1 = 1'b0;
			brk2 = c2_fire && armed_now;
			armed_d = (armed_q || c1_match) && !brk2;
		end else begin
			brk1 = c1_match;
			brk2 = c2_fire;
			armed_d = 1'b0;
		end
		fset = 4'h0;
		fset[CT_F1CPU] = brk1 && !bus_dma;
		fset[CT_F1DMA] = brk1 && bus_dma;
		fset[CT_F2CPU] = brk2 && !c2_dma;
		fset[CT_F2DMA] = brk2 && c2_dma;
		fclr = wr_ctrl ? ~reg_wdata[3:0] : 4'h0;
		// a new match beats a clear in the same cycle
		flags_d = (flags_q & ~fclr) | fset;
		brk_d = brk1 || brk2;
		after_d = brk2 ? pp2_q : pp1_q;
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			flags_q <= FLAGS_RST;
			armed_q <= 1'b0;
			exec_q <= CNT_W'(EXEC_RST);
			brk_q <= 1'b0;
			after_q <= 1'b0;
		end else if (ce) begin
			flags_q <= flags_d;
			armed_q <= armed_d;
			exec_q <= exec_d;
			brk_q <= brk_d;
			after_q <= after_d;
		end
	end

	assign break_req = brk_q;
	assign break_after_exec = after_q;
	assign break_level = BREAK_LEVEL;

	// branch trace queue
	logic [31:0] src_q [DEPTH];
	logic [31:0] src_d [DEPTH];
	logic [31:0] dst_q [DEPTH];
	logic [31:0] dst_d [DEPTH];
	logic [TF_PTR_W:0] tfl_q [DEPTH];
	logic [TF_PTR_W:0] tfl_d [DEPTH];
	logic [PW-1:0] head_q, head_d, slot;
	logic [PW:0] cnt_q, cnt_d;
	logic push, pop;

	always_comb begin
		src_d = src_q;
		dst_d = dst_q;
		tfl_d = tfl_q;
		head_d = head_q;
		cnt_d = cnt_q;
		slot = head_q;
		pop = reg_re && reg_addr == OFS_TDST && cnt_q != '0;
		push = trace_en_q && br_take && !br_short_repeat;
		if (pop) begin
			head_d = head_d + PW'(1);
			cnt_d = cnt_d - (PW+1)'(1);
		end
		if (push) begin
			if (cnt_d == (PW+1)'(DEPTH)) begin
				slot = head_d;
				head_d = head_d + PW'(1);
			end else begin
				slot = head_d + cnt_d[PW-1:0];
				cnt_d = cnt_d + (PW+1)'(1);
			end
			dst_d[slot] = br_dest;
			if (br_delay_intr && br_pending_dest[1]) begin
				src_d[slot] = br_pending_dest;
				tfl_d[slot] = {1'b0, br_pointer};
			end else begin
				src_d[slot] = br_last_fetch;
				tfl_d[slot] = {1'b1, br_pointer};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				src_q[i] <= 32'h0;
				dst_q[i] <= 32'h0;
				tfl_q[i] <= '0;
			end
			head_q <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			src_q <= src_d;
			dst_q <= dst_d;
			tfl_q <= tfl_d;
			head_q <= head_d;
			cnt_q <= cnt_d;
		end
	end

	// read port: data valid the cycle after the strobe
	logic [31:0] rdata_q, rdata_d;
	logic have;

	always_comb begin
		have = cnt_q != '0;
		rdata_d = 32'h0;
		if (reg_re) begin
			if (reg_addr == OFS_C1_ADDR) begin
				rdata_d = c1_addr_q;
			end else if (reg_addr == OFS_C1_AMASK) begin
				rdata_d = c1_amask_q;
			end else if (reg_addr == OFS_C1_BUS) begin
				rdata_d = {22'h0, c1_bus_q};
			end else if (reg_addr == OFS_C2_ADDR) begin
				rdata_d = c2_addr_q;
			end else if (reg_addr == OFS_C2_AMASK) begin
				rdata_d = c2_amask_q;
			end else if (reg_addr == OFS_C2_DATA) begin
				rdata_d = c2_data_q;
			end else if (reg_addr == OFS_C2_DMASK) begin
				rdata_d = c2_dmask_q;
			end else if (reg_addr == OFS_C2_BUS) begin
				rdata_d = {22'h0, c2_bus_q};
			end else if (reg_addr == OFS_CTRL) begin
				rdata_d = {23'h0, trace_en_q, exec_en_q, seq_q, pp2_q, pp1_q,
					flags_q};
			end else if (reg_addr == OFS_EXEC) begin
				rdata_d = 32'(exec_q);
			end else if (reg_addr == OFS_TFLAG && have) begin
				rdata_d = {1'b1, 26'h0, tfl_q[head_q]};
			end else if (reg_addr == OFS_TSRC && have) begin
				rdata_d = src_q[head_q];
			end else if (reg_addr == OFS_TDST && have) begin
				rdata_d = dst_q[head_q];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rdata_q <= 32'h0;
		end else if (ce) begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
endmodule : ubs_break_unit

// ==== hw/ubs_chan_cmp.sv ====
`timescale 1ns/10ps
module ubs_chan_cmp #(
	parameter bit HAS_DATA = 1'b0
) (
	input wire logic [ubs_pkg::BUS_W-1:0] cyc,
	input wire logic [31:0] bar,
	input wire logic [31:0] bamr,
	input wire logic [31:0] bdr,
	input wire logic [31:0] bdmr,
	input wire logic valid,
	input wire logic dma,
	input wire logic fetch,
	input wire logic write,
	input wire logic [1:0] size,
	input wire logic [31:0] addr,
	input wire logic [31:0] data,
	output logic match
);
	import ubs_pkg::*;

	logic [1:0] csz;
	logic [31:0] gmask;
	logic [31:0] dwin;
	logic who_ok;
	logic kind_ok;
	logic rw_ok;
	logic size_ok;
	logic addr_ok;
	logic data_ok;

	always_comb begin
		csz = cyc[BC_SIZE +: 2];
		gmask = (size == BSZ_LONG) ? 32'h0000_0003 :
			(size == BSZ_WORD) ? 32'h0000_0001 : 32'h0000_0000;
		dwin = (csz == CSZ_BYTE) ? 32'h0000_00ff :
			(csz == CSZ_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
		// a group other than size left at 00 can never match; size 00 matches any size
		who_ok = dma ? cyc[BC_DMA] : cyc[BC_CPU];
		kind_ok = fetch ? cyc[BC_FETCH] : cyc[BC_DATA];
		rw_ok = (write && !fetch) ? cyc[BC_WR] : cyc[BC_RD];
		size_ok = (csz == CSZ_NONE) || (csz == size + 2'h1);
		addr_ok = (((addr ^ bar) & ~(bamr | gmask)) == 32'h0) &&
			!(fetch && bar[0]);
		data_ok = !HAS_DATA || fetch || (csz == CSZ_NONE) ||
			(((data ^ bdr) & dwin & ~bdmr) == 32'h0);
		match = valid && who_ok && kind_ok && rw_ok && size_ok &&
			addr_ok && data_ok;
	end
endmodule : ubs_chan_cmp

// ==== hw/ubs_pkg.sv ====
package ubs_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_C1_ADDR = 8'h00;
	localparam logic [7:0] OFS_C1_AMASK = 8'h04;
	localparam logic [7:0] OFS_C1_BUS = 8'h08;
	localparam logic [7:0] OFS_C2_ADDR = 8'h0c;
	localparam logic [7:0] OFS_C2_AMASK = 8'h10;
	localparam logic [7:0] OFS_C2_DATA = 8'h14;
	localparam logic [7:0] OFS_C2_DMASK = 8'h18;
	localparam logic [7:0] OFS_C2_BUS = 8'h1c;
	localparam logic [7:0] OFS_CTRL = 8'h20;
	localparam logic [7:0] OFS_EXEC = 8'h24;
	localparam logic [7:0] OFS_TFLAG = 8'h28;
	localparam logic [7:0] OFS_TSRC = 8'h2c;
	localparam logic [7:0] OFS_TDST = 8'h30;

	// bus cycle register fields
	localparam int BUS_W = 10;
	localparam int BC_CPU = 0;
	localparam int BC_DMA = 1;
	localparam int BC_FETCH = 2;
	localparam int BC_DATA = 3;
	localparam int BC_RD = 4;
	localparam int BC_WR = 5;
	localparam int BC_SIZE = 6;
	localparam int BC_XYE = 8;
	localparam int BC_XYS = 9;
	localparam logic [BUS_W-1:0] BUS_RST = 10'h000;

	// size codes: condition field and observed bus size
	localparam logic [1:0] CSZ_NONE = 2'h0;
	localparam logic [1:0] CSZ_BYTE = 2'h1;
	localparam logic [1:0] CSZ_WORD = 2'h2;
	localparam logic [1:0] CSZ_LONG = 2'h3;
	localparam logic [1:0] BSZ_BYTE = 2'h0;
	localparam logic [1:0] BSZ_WORD = 2'h1;
	localparam logic [1:0] BSZ_LONG = 2'h2;

	// break control register fields
	localparam int CT_F1CPU = 0;
	localparam int CT_F1DMA = 1;
	localparam int CT_F2CPU = 2;
	localparam int CT_F2DMA = 3;
	localparam int CT_PP1 = 4;
	localparam int CT_PP2 = 5;
	localparam int CT_SEQ = 6;
	localparam int CT_EXEC = 7;
	localparam int CT_TRACE = 8;
	localparam logic [3:0] FLAGS_RST = 4'h0;

	// trace flag register fields
	localparam int TF_PTR_W = 4;
	localparam int TF_PVALID = 4;
	localparam int TF_EVALID = 31;

	localparam int EXEC_W = 16;
	localparam logic [EXEC_W-1:0] EXEC_RST = 16'h0000;
	localparam logic [EXEC_W-1:0] EXEC_LAST = 16'h0001;
	localparam int TRACE_DEPTH = 4;
	localparam logic [3:0] BREAK_LEVEL = 4'hf;
endpackage : ubs_pkg

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	import ubs_pkg::*;
	logic clk_sys, nrst, ce, reg_we, reg_re, xy_valid, xy_is_y, xy_write, in;
	logic bus_valid, bus_dma, bus_fetch, bus_write, break_req, break_after_exec;
	logic br_take, br_short_repeat, br_delay_intr;
	logic [1:0] bus_size;
	logic [3:0] br_pointer, break_level, p;
	logic [7:0] reg_addr;
	logic [15:0] xy_addr, xy_data;
	logic [31:0] reg_wdata, reg_rdata, bus_addr, bus_data, br_dest;
	logic [31:0] br_last_fetch, br_pending_dest, v, e, mk, d, l, pd;
	logic [31:0] q[$];
	int err_total, total_checks, cnt_m;
	bit seq_m, exe_m, arm_m, same_m;
	ubs_break_unit i_dut (
		.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .bus_valid(bus_valid), .bus_dma(bus_dma),
		.bus_fetch(bus_fetch), .bus_write(bus_write), .bus_size(bus_size),
		.bus_addr(bus_addr), .bus_data(bus_data), .xy_valid(xy_valid),
		.xy_is_y(xy_is_y), .xy_write(xy_write), .xy_addr(xy_addr),
		.xy_data(xy_data), .br_take(br_take), .br_short_repeat(br_short_repeat),
		.br_dest(br_dest), .br_last_fetch(br_last_fetch),
		.br_pointer(br_pointer), .br_delay_intr(br_delay_intr),
		.br_pending_dest(br_pending_dest), .break_req(break_req),
		.break_after_exec(break_after_exec), .break_level(break_level));
	ubs_core_model i_core (
		.clk_sys(clk_sys), .bus_valid(bus_valid), .bus_dma(bus_dma),
		.bus_fetch(bus_fetch), .bus_write(bus_write), .bus_size(bus_size),
		.bus_addr(bus_addr), .bus_data(bus_data), .xy_valid(xy_valid),
		.xy_is_y(xy_is_y), .xy_write(xy_write), .xy_addr(xy_addr),
		.xy_data(xy_data), .br_take(br_take), .br_short_repeat(br_short_repeat),
		.br_dest(br_dest), .br_last_fetch(br_last_fetch),
		.br_pointer(br_pointer), .br_delay_intr(br_delay_intr),
		.br_pending_dest(br_pending_dest));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] s, x);
		total_checks++;
		if (s !== x) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk_sys);
		{reg_we, reg_addr, reg_wdata} <= {1'b1, a, x};
		@(posedge clk_sys);
		reg_we <= 1'b0;
	endtask : wr
	task automatic cmp(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk_sys);
		{reg_re, reg_addr} <= {1'b1, a};
		@(posedge clk_sys);
		reg_re <= 1'b0;
		#1 v = reg_rdata;
		chk(v, x);
	endtask : cmp
	task automatic ctl(input logic [31:0] x);
		wr(OFS_CTRL, x);
		{exe_m, seq_m} = {x[CT_EXEC], x[CT_SEQ]};
		// clearing the sequence bit drops a pending first-channel hit
		arm_m = arm_m && seq_m;
	endtask : ctl
	// break expectation from channel hits, sequence arming and count
	function automatic bit want(input bit m1, m2);
		bit f, h;
		h = m2 && (!exe_m || cnt_m == 1);
		// with counting on, every channel two hit above a count of one counts down, armed or not
		if (m2 && exe_m && cnt_m > 1)
			cnt_m--;
		f = (m1 && !seq_m) || (h && (!seq_m || arm_m || (m1 && same_m)));
		arm_m = seq_m && !f && (arm_m || m1);
		return f;
	endfunction : want
	function automatic logic [31:0] nxt;
		if (q.size() == 0)
			return 32'h0;
		return q.pop_front();
	endfunction : nxt
	// k = {chan1 hit, chan2 hit, fetch, write}
	task automatic cyc(input logic [3:0] k, input logic [31:0] a);
		i_core.main(1'b0, k[1], k[0], BSZ_WORD, a, 32'h0000_4567);
		#1 chk({31'h0, break_req}, {31'h0, want(k[3], k[2])});
	endtask : cyc
	// k = {y bus, write, chan2 hit}
	task automatic xyc(input logic [2:0] k, input logic [15:0] a, x);
		i_core.xy(k[2], k[1], a, x);
		#1 chk({31'h0, break_req}, {31'h0, want(1'b0, k[0])});
	endtask : xyc
	initial begin
		#60000;
		err_total++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'hb9eac596));
		{nrst, ce, reg_we, reg_re, reg_addr, reg_wdata} = 44'h400_0000_0000;
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		cmp(OFS_CTRL, 32'h0);
		cmp(OFS_C2_BUS, 32'h0);
		cmp(OFS_TFLAG, 32'h0);
		wr(8'hfc, 32'hffff_ffff);
		cmp(8'hfc, 32'h0);
		wr(OFS_C1_BUS, 32'h3ff);
		cmp(OFS_C1_BUS, 32'h0ff);
		wr(OFS_C2_ADDR, 32'h1234_5678);
		wr(OFS_C2_DATA, 32'ha512_4567);
		wr(OFS_C2_BUS, 32'h1a9);
		ctl(32'h0);
		xyc(3'h3, 16'h1234, 16'ha512);
		xyc(3'h6, 16'h1234, 16'ha512);
		cyc(4'h1, 32'h1234_5678);
		cmp(OFS_CTRL, 32'h4);
		ctl(32'h0);
		cmp(OFS_CTRL, 32'h0);
		wr(OFS_C2_BUS, 32'h3a9);
		xyc(3'h7, 16'h5678, 16'h4567);
		xyc(3'h2, 16'h5678, 16'h4567);
		wr(OFS_C1_ADDR, 32'h400);
		wr(OFS_C1_BUS, 32'h19);
		wr(OFS_C2_ADDR, 32'h800);
		wr(OFS_C2_BUS, 32'h19);
		ctl(32'h40);
		cyc(4'h4, 32'h800);
		cyc(4'h8, 32'h400);
		cyc(4'h4, 32'h800);
		cyc(4'h4, 32'h800);
		cmp(OFS_CTRL, 32'h44);
		wr(OFS_EXEC, 32'h3);
		cnt_m = 3;
		ctl(32'hc0);
		for (int i = 0; i < 5; i++) begin
			cyc(i[0] || i == 4 ? 4'h4 : 4'h8, i[0] || i == 4 ? 32'h800 : 32'h400);
		end
		cmp(OFS_EXEC, 32'h1);
		wr(OFS_C1_ADDR, 32'h800);
		ctl(32'h40);
		cyc(4'hc, 32'h800);
		wr(OFS_C1_BUS, 32'h15);
		wr(OFS_C2_BUS, 32'h15);
		ctl(32'h0);
		ctl(32'h40);
		same_m = 1'b1;
		cyc(4'he, 32'h800);
		same_m = 1'b0;
		wr(OFS_C1_ADDR, 32'h400);
		wr(OFS_EXEC, 32'h5);
		cnt_m = 5;
		ctl(32'h80);
		repeat (5) cyc(4'h6, 32'h800);
		ctl(32'h20);
		cyc(4'h6, 32'h800);
		chk({31'h0, break_after_exec}, 32'h1);
		ctl(32'h0);
		// a frozen block must ignore a matching cycle
		ce <= 1'b0;
		i_core.main(1'b0, 1'b1, 1'b0, BSZ_WORD, 32'h800, 32'h0);
		ce <= 1'b1;
		#1 chk({31'h0, break_req}, 32'h0);
		cmp(OFS_CTRL, 32'h0);
		wr(OFS_C1_BUS, 32'h25);
		wr(OFS_C2_ADDR, 32'h801);
		ctl(32'h0);
		cyc(4'h2, 32'h400);
		cyc(4'h2, 32'h800);
		i_core.branch(1'b0, 1'b0, 4'h3, 32'h100, 32'h200, 32'h0);
		cmp(OFS_TFLAG, 32'h0);
		ctl(32'h100);
		for (int i = 0; i < 7; i++) begin
			{p, in, d, l, pd} = {4'($urandom), 1'($urandom), $urandom, $urandom, $urandom};
			i_core.branch(i == 0, in, p, d, l, pd);
			if (i != 0) begin
				q.push_back({1'b1, 26'h0, !(in && pd[1]), p});
				q.push_back(in && pd[1] ? pd : l);
				q.push_back(d);
			end
			if (q.size() > 12)
				q = q[3:$];
		end
		// flag, source, destination; the last read moves the queue
		repeat (5) begin
			e = nxt();
			mk = e[TF_PVALID] ? 32'hffff_ffff : 32'hffff_fff0;
			cmp(OFS_TFLAG, e);
			chk(v & mk, e & mk);
			cmp(OFS_TSRC, nxt());
			cmp(OFS_TDST, nxt());
		end
		end_of_test();
	end
endmodule : tb_top

// ==== tb/ubs_core_model.sv ====
`timescale 1ns/10ps
module ubs_core_model (
	input wire logic clk_sys,
	output logic bus_valid,
	output logic bus_dma,
	output logic bus_fetch,
	output logic bus_write,
	output logic [1:0] bus_size,
	output logic [31:0] bus_addr,
	output logic [31:0] bus_data,
	output logic xy_valid,
	output logic xy_is_y,
	output logic xy_write,
	output logic [15:0] xy_addr,
	output logic [15:0] xy_data,
	output logic br_take,
	output logic br_short_repeat,
	output logic [31:0] br_dest,
	output logic [31:0] br_last_fetch,
	output logic [3:0] br_pointer,
	output logic br_delay_intr,
	output logic [31:0] br_pending_dest
);
	initial begin
		{bus_valid, bus_dma, bus_fetch, bus_write, bus_size} = 6'h0;
		{bus_addr, bus_data, xy_valid, xy_is_y, xy_write} = 67'h0;
		{xy_addr, xy_data, br_take, br_short_repeat, br_delay_intr} = 35'h0;
		{br_dest, br_last_fetch, br_pointer, br_pending_dest} = 100'h0;
	end
	// released lines show the inverse so stale values never match
	task automatic main(input logic m, f, w, input logic [1:0] s,
		input logic [31:0] a, d);
		@(posedge clk_sys);
		{bus_valid, bus_dma, bus_fetch, bus_write} <= {1'b1, m, f, w};
		{bus_size, bus_addr, bus_data} <= {s, a, d};
		@(posedge clk_sys);
		{bus_valid, bus_dma, bus_fetch, bus_write} <= {1'b0, ~m, ~f, ~w};
		{bus_addr, bus_data} <= {~a, ~d};
	endtask : main
	task automatic xy(input logic y, w, input logic [15:0] a, d);
		@(posedge clk_sys);
		{xy_valid, xy_is_y, xy_write, xy_addr, xy_data} <= {1'b1, y, w, a, d};
		@(posedge clk_sys);
		{xy_valid, xy_is_y, xy_write, xy_addr, xy_data} <= {1'b0, ~y, ~w, ~a, ~d};
	endtask : xy
	task automatic branch(input logic s, i, input logic [3:0] p,
		input logic [31:0] d, l, pd);
		@(posedge clk_sys);
		{br_take, br_short_repeat, br_delay_intr, br_pointer} <= {1'b1, s, i, p};
		{br_dest, br_last_fetch, br_pending_dest} <= {d, l, pd};
		@(posedge clk_sys);
		{br_take, br_short_repeat, br_delay_intr, br_pointer} <= {3'h0, ~p};
		{br_dest, br_last_fetch, br_pending_dest} <= {~d, ~l, ~pd};
	endtask : branch
endmodule : ubs_core_model

// ==== tb/ubs_props.sv ====
`timescale 1ns/10ps
module ubs_props #(
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [31:0] reg_rdata,
	input wire logic bus_valid,
	input wire logic xy_valid,
	input wire logic br_take,
	input wire logic br_short_repeat,
	input wire logic break_req,
	input wire logic [3:0] break_level
);
	import ubs_pkg::*;
	logic te_q, te_d, push, pop, seen, rd_flag, rd_dst;
	logic [3:0] cnt_q, cnt_d;
	// shadow occupancy so head reads can be judged without the bodies
	always_comb begin
		seen = ce && (bus_valid || xy_valid);
		rd_flag = ce && reg_re && reg_addr == OFS_TFLAG;
		rd_dst = ce && reg_re && reg_addr == OFS_TDST;
		push = ce && te_q && br_take && !br_short_repeat;
		pop = rd_dst && cnt_q != 4'h0;
		te_d = te_q;
		if (ce && reg_we && reg_addr == OFS_CTRL) begin
			te_d = reg_wdata[CT_TRACE];
		end
		cnt_d = cnt_q - {3'h0, pop};
		if (push && cnt_d < 4'(DEPTH)) begin
			cnt_d = cnt_d + 4'h1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			te_q <= 1'b0;
			cnt_q <= 4'h0;
		end else begin
			te_q <= te_d;
			cnt_q <= cnt_d;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_level_fixed: assert property (break_level == BREAK_LEVEL)
		else $error("break level is not fifteen");
	a_rdata_quiet: assert property (!(ce && reg_re) |=> reg_rdata == 32'h0)
		else $error("read data present without a read");
	a_reset_quiet: assert property (disable iff (1'b0)
		!nrst |=> !break_req && reg_rdata == 32'h0)
		else $error("outputs active after reset");
	a_chan1_no_xy: assert property (ce && reg_re &&
		reg_addr == OFS_C1_BUS |=> reg_rdata[9:8] == 2'h0)
		else $error("channel one shows x/y bits");
	a_trace_empty: assert property (rd_flag && cnt_q == 4'h0
		|=> reg_rdata == 32'h0)
		else $error("empty trace queue reads non-zero");
	a_trace_head: assert property (rd_flag && cnt_q != 4'h0
		|=> reg_rdata[TF_EVALID])
		else $error("queued trace entry not valid");
	a_dst_empty: assert property (rd_dst && !pop |=> reg_rdata == 32'h0)
		else $error("destination read on empty queue non-zero");
	a_break_cause: assert property (break_req |-> $past(seen))
		else $error("break without a bus cycle before it");
endmodule : ubs_props
bind ubs_break_unit ubs_props #(.DEPTH(DEPTH)) i_props (
	.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
	.reg_rdata(reg_rdata), .bus_valid(bus_valid), .xy_valid(xy_valid),
	.br_take(br_take), .br_short_repeat(br_short_repeat),
	.break_req(break_req), .break_level(break_level));
